// ### inc/dprl_pkg.sv
package dprl_pkg;

  // Clock and sampling schedule
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned SAMPLE_PERIOD_MS = 40;
  localparam int unsigned SAMPLE_CYCLES    =
    (SAMPLE_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W            = 24;

  // Function selector states
  localparam logic [2:0] SEL_ATT_HOLD     = 3'h0;
  localparam logic [2:0] SEL_RENDEZVOUS   = 3'h1;
  localparam logic [2:0] SEL_ACQUISITION  = 3'h2;
  localparam logic [2:0] SEL_XFER_ALIGN   = 3'h3;
  localparam logic [2:0] SEL_LUNAR_ALIGN  = 3'h4;
  localparam logic [2:0] SEL_BODY_ALIGN   = 3'h5;
  localparam logic [2:0] SEL_FLIGHT_CAL   = 3'h6;
  localparam logic [2:0] SEL_ACCEL_CAL    = 3'h7;
  localparam logic [2:0] SEL_RESET        = 3'h0;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_GSE_WORD = 12'h008;
  localparam logic [11:0] REG_RO_SEL   = 12'h00c;
  localparam logic [11:0] REG_RO_DATA  = 12'h010;
  localparam logic [11:0] REG_RO_BASE  = 12'h100;

  // Field positions
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_LUNAR    = 4;
  localparam int unsigned ST_LUNAR      = 6;
  localparam int unsigned ST_STAGED     = 7;
  localparam int unsigned ST_GSE_VALID  = 8;
  localparam int unsigned ST_GSE_END    = 9;
  localparam int unsigned ST_SEL_LSB    = 12;

  // Readout list, one word per quantity, counts in quantization steps
  localparam int unsigned RO_DEPTH      = 16;
  localparam int unsigned RO_IDX_W      = 4;
  localparam logic [3:0]  RO_IDX_DVG_X  = 4'h0;
  localparam logic [3:0]  RO_IDX_DVG_Y  = 4'h1;
  localparam logic [3:0]  RO_IDX_DVG_Z  = 4'h2;
  localparam logic [3:0]  RO_IDX_DT_TPI = 4'h3;
  localparam int unsigned DVG_LSB_MFPS  = 100;
  localparam int unsigned DT_TPI_LSB_CMIN = 1;

  localparam int unsigned GSE_W = 16;

  // Vehicle discretes as one carrier
  typedef struct packed {
    logic abort;
    logic abort_stage;
    logic asc_on;
    logic dsc_on;
    logic auto_mode;
    logic follow_up;
  } dprl_disc_t;

endpackage

// ### rtl/dprl_top.sv
`timescale 1ns/1ns
// Functional notes
// - Sample abort every 40 ms, feed mode select with other discretes.
// - Abort stage sampled and used exactly like abort.
// - Ascent engine on sampled every 40 ms, passed to engine logic.
// - Sampled ascent engine on marks staging, clears lunar surface flag.
// - Sampled ascent engine on drives staging attitude hold.
// - Descent engine on sampled every 40 ms, passed to engine logic.
// - Automatic sampled every 40 ms only in inertial reference states.
// - Followup sampled in the loop only in inertial reference states.
// - Ground test transfer uses word strobe and block end flag only.
// - Listed quantities can be read out through the keypad display.
// - Velocity to be gained body components, 0.1 fps steps, readable.
// - Time increment to terminal phase, 0.01 min steps, readable.
// - Readout list storage extensible with minimal impact.
// - Function selector has eight states, zero is attitude hold.
// - Selector switches are forced to zero at power on.
module dprl_top
  import dprl_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire dprl_disc_t  i_disc,
  input  wire logic        i_word_sent_strobe,
  input  wire logic        i_block_end_flag,
  input  wire logic [15:0] i_gse_word,
  output dprl_disc_t       o_disc,
  output logic             o_sample_tick,
  output logic             o_staged,
  output logic             o_lunar_surface_flag,
  output logic             o_att_hold_staging,
  output logic [2:0]       o_function_selector,
  output logic [15:0]      o_gse_word,
  output logic             o_gse_word_valid,
  output logic             o_gse_block_end,
  output logic [31:0]      o_kdu_data
);

  // Inertial reference states gate automatic and followup
  function automatic logic is_inertial(input logic [2:0] s);
    return (s == SEL_ATT_HOLD) || (s == SEL_RENDEZVOUS) ||
           (s == SEL_ACQUISITION);
  endfunction

  // Readout window decode
  function automatic logic in_ro(input logic [11:0] a);
    return a[11:6] == REG_RO_BASE[11:6];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return in_ro(a) || a == REG_CTRL || a == REG_STATUS ||
           a == REG_GSE_WORD || a == REG_RO_SEL || a == REG_RO_DATA;
  endfunction

  logic [CNT_W-1:0]    cnt_q;
  logic                tick;
  dprl_disc_t          disc_m_q;
  dprl_disc_t          disc_s_q;
  dprl_disc_t          samp_q;
  logic [2:0]          sel_q;
  logic                lunar_q;
  logic                staged_q;
  logic [2:0]          strb_q;
  logic [1:0]          end_q;
  logic [GSE_W-1:0]    word_m_q;
  logic [GSE_W-1:0]    word_s_q;
  logic [GSE_W-1:0]    gse_word_q;
  logic                gse_valid_q;
  logic                gse_end_q;
  logic                strb_rise;
  logic [31:0]         ro_q [RO_DEPTH];
  logic [RO_IDX_W-1:0] ro_sel_q;
  logic [31:0]         kdu_q;
  logic [31:0]         prdata_q;
  logic                err_q;
  logic [31:0]         rd_d;
  logic                setup;
  logic                wr;
  logic                rd;
  logic [31:0]         status;

  // APB phases; writes land in the access cycle
  assign setup = i_psel && !i_penable;
  assign wr    = i_psel && i_penable && i_pwrite;
  assign rd    = i_psel && i_penable && !i_pwrite;

  // 40 ms schedule counter, one tick per period
  assign tick = cnt_q == CNT_W'(SAMPLE_CYC - 1);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Two-stage synchronisers for every pin
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      disc_m_q <= '0;
      disc_s_q <= '0;
      strb_q   <= '0;
      end_q    <= '0;
      word_m_q <= '0;
      word_s_q <= '0;
    end else begin
      disc_m_q <= i_disc;
      disc_s_q <= disc_m_q;
      strb_q   <= {strb_q[1:0], i_word_sent_strobe};
      end_q    <= {end_q[0], i_block_end_flag};
      word_m_q <= i_gse_word;
      word_s_q <= word_m_q;
    end
  end

  // Edge taken after the second stage; the word bits change with the strobe
  // and pass the same two stages, so they are stable by the time it is seen
  assign strb_rise = strb_q[1] && !strb_q[2];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      samp_q <= '0;
    end else if (tick) begin
      samp_q.abort       <= disc_s_q.abort;
      samp_q.abort_stage <= disc_s_q.abort_stage;
      samp_q.asc_on      <= disc_s_q.asc_on;
      samp_q.dsc_on      <= disc_s_q.dsc_on;
      if (is_inertial(sel_q)) begin
        samp_q.auto_mode <= disc_s_q.auto_mode;
        samp_q.follow_up <= disc_s_q.follow_up;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_q <= SEL_RESET;
    end else if (wr && i_paddr == REG_CTRL) begin
      sel_q <= i_pwdata[CTRL_SEL_LSB +: 3];
    end
  end

  // ascent engine clears lunar surface flag over software
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lunar_q <= 1'b0;
    end else if (samp_q.asc_on) begin
      lunar_q <= 1'b0;
    end else if (wr && i_paddr == REG_CTRL) begin
      lunar_q <= i_pwdata[CTRL_LUNAR];
    end
  end

  // sticky staging flag, write one to clear, set wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      staged_q <= 1'b0;
    end else if (samp_q.asc_on) begin
      staged_q <= 1'b1;
    end else if (wr && i_paddr == REG_STATUS && i_pwdata[ST_STAGED]) begin
      staged_q <= 1'b0;
    end
  end

  // word capture on strobe, end flag taken with it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gse_word_q <= '0;
      gse_end_q  <= 1'b0;
    end else if (strb_rise) begin
      gse_word_q <= word_s_q;
      gse_end_q  <= end_q[1];
    end
  end

  // Word valid cleared by reading the word; a new word wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gse_valid_q <= 1'b0;
    end else if (strb_rise) begin
      gse_valid_q <= 1'b1;
    end else if (rd && i_paddr == REG_GSE_WORD) begin
      gse_valid_q <= 1'b0;
    end
  end

  // readout list indexed storage, new slots need no new decode
  // slot 3 terminal phase time increment
  // Spare slots 4 to 15 leave room for later quantities
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < RO_DEPTH; i++) begin
        ro_q[i] <= '0;
      end
    end else if (wr && in_ro(i_paddr)) begin
      ro_q[i_paddr[2 +: RO_IDX_W]] <= i_pwdata;
    end
  end

  // keypad display readout of the selected quantity
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ro_sel_q <= '0;
      kdu_q    <= '0;
    end else begin
      if (wr && i_paddr == REG_RO_SEL) begin
        ro_sel_q <= i_pwdata[RO_IDX_W-1:0];
      end
      kdu_q <= ro_q[ro_sel_q];
    end
  end

  // Status word
  always_comb begin
    status = '0;
    status[5:0]              = samp_q;
    status[ST_LUNAR]         = lunar_q;
    status[ST_STAGED]        = staged_q;
    status[ST_GSE_VALID]     = gse_valid_q;
    status[ST_GSE_END]       = gse_end_q;
    status[ST_SEL_LSB +: 3]  = sel_q;
  end

  // Read mux, evaluated during setup
  always_comb begin
    rd_d = '0;
    if (in_ro(i_paddr)) begin
      rd_d = ro_q[i_paddr[2 +: RO_IDX_W]];
    end else if (i_paddr == REG_CTRL) begin
      rd_d = {27'h0, lunar_q, 1'b0, sel_q};
    end else if (i_paddr == REG_STATUS) begin
      rd_d = status;
    end else if (i_paddr == REG_GSE_WORD) begin
      rd_d = {16'h0, gse_word_q};
    end else if (i_paddr == REG_RO_SEL) begin
      rd_d = {28'h0, ro_sel_q};
    end else if (i_paddr == REG_RO_DATA) begin
      rd_d = kdu_q;
    end
  end

  // Read data and error captured in setup, so access needs no wait
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= i_pwrite ? 32'h0 : rd_d;
      err_q    <= !mapped(i_paddr);
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && err_q;

  // Outputs to mode select, engine logic and staging
  assign o_disc               = samp_q;
  assign o_sample_tick        = tick;
  assign o_staged             = staged_q;
  assign o_lunar_surface_flag = lunar_q;
  assign o_att_hold_staging   = samp_q.asc_on;
  assign o_function_selector  = sel_q;
  assign o_gse_word           = gse_word_q;
  assign o_gse_word_valid     = gse_valid_q;
  assign o_gse_block_end      = gse_end_q;
  assign o_kdu_data           = kdu_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Reset disables every check below

  AST_ABORT_TAKE: assert property (
    tick |=> samp_q.abort == $past(disc_s_q.abort))
    else $error("abort not sampled on tick");
  AST_ABSTG_TAKE: assert property (
    tick |=> samp_q.abort_stage == $past(disc_s_q.abort_stage))
    else $error("abort stage not sampled on tick");
  AST_ENGINE_TAKE: assert property (
    tick |=> samp_q.asc_on == $past(disc_s_q.asc_on)
             && samp_q.dsc_on == $past(disc_s_q.dsc_on))
    else $error("engine discretes not sampled");
  AST_HOLD: assert property (
    !tick |=> $stable(samp_q))
    else $error("sample changed between ticks");
  AST_GATED: assert property (
    tick && !is_inertial(sel_q) |=> $stable(samp_q.auto_mode)
                                    && $stable(samp_q.follow_up))
    else $error("auto or followup sampled outside inertial");
  AST_STAGING: assert property (
    tick && disc_s_q.asc_on ##1 1 |=> staged_q && !lunar_q)
    else $error("staging not marked after ascent engine");
  AST_ATT_HOLD: assert property (
    tick |=> o_att_hold_staging == $past(disc_s_q.asc_on))
    else $error("attitude hold not tied to ascent engine");
  AST_STAGED_SET: assert property (
    samp_q.asc_on |=> o_staged && !o_lunar_surface_flag)
    else $error("staging not held while ascent engine on");
  AST_GSE_WORD: assert property (
    strb_rise |=> gse_valid_q && gse_word_q == $past(word_s_q)
                  && gse_end_q == $past(end_q[1]))
    else $error("test word not captured on strobe");
  AST_SEL_RESET: assert property (
    $rose(i_rst_n) |-> sel_q == SEL_RESET && !lunar_q)
    else $error("selector not zero after reset");
  AST_READOUT: assert property (
    $stable(ro_sel_q) && !wr |=> kdu_q == ro_q[ro_sel_q])
    else $error("readout data does not track selected slot");
  AST_RO_WRITE: assert property (
    wr && in_ro(i_paddr) |=> ro_q[$past(i_paddr[2 +: RO_IDX_W])]
                             == $past(i_pwdata))
    else $error("readout slot write lost");
  AST_STAGED_KEEP: assert property (
    staged_q && !(wr && i_paddr == REG_STATUS && i_pwdata[ST_STAGED])
    |=> staged_q)
    else $error("staging flag lost without clear");
  AST_GSE_CLR: assert property (
    rd && i_paddr == REG_GSE_WORD && !strb_rise |=> !gse_valid_q)
    else $error("word valid not cleared by read");
  AST_SEL_WRITE: assert property (
    wr && i_paddr == REG_CTRL |=> sel_q == $past(i_pwdata[2:0]))
    else $error("selector write lost");
  AST_CNT_RANGE: assert property (
    cnt_q <= CNT_W'(SAMPLE_CYC - 1))
    else $error("schedule counter skipped its tick");

endmodule

// ### tb/dprl_partner.sv
`timescale 1ns/1ns
// Vehicle discretes and ground test equipment
module dprl_partner
  import dprl_pkg::*;
(
  input  wire logic        i_clk,
  input  wire dprl_disc_t  i_disc_req,
  input  wire logic        i_send,
  input  wire logic        i_last,
  input  wire logic [15:0] i_word,
  output dprl_disc_t       o_disc,
  output logic             o_strobe,
  output logic             o_end,
  output logic [15:0]      o_word
);
  logic [3:0] cnt;
  initial begin
    o_disc = '0;
    o_strobe = 1'b0;
    o_end = 1'b0;
    o_word = 16'h0000;
    cnt = 4'h0;
  end
  // Discrete levels follow the request one edge later
  always @(posedge i_clk) begin
    o_disc <= i_disc_req;
  end
  // strobe with end flag
  // Strobe high 4 cycles, low at least 4; word then goes stale (inverted)
  always @(posedge i_clk) begin
    if (i_send && cnt == 4'h0) begin
      o_word <= i_word;
      o_end <= i_last;
      o_strobe <= 1'b1;
      cnt <= 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h5) o_strobe <= 1'b0;
      if (cnt == 4'h2) begin
        o_word <= ~o_word;
        o_end <= ~o_end;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import dprl_pkg::*;
;
  logic clk, rst_n, psel, pen, pwr, send, last;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, kdu;
  logic pready, pslverr, strobe, bend, tick, staged;
  logic lunar, ahold, gvalid, gend;
  logic [15:0] gw_in, gw_pin, gword;
  logic [2:0] fsel;
  dprl_disc_t dreq, dpin, dout;
  int n_errors, checks_done;

  dprl_top #(.SAMPLE_CYC(20)) dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_disc(dpin), .i_word_sent_strobe(strobe),
    .i_block_end_flag(bend), .i_gse_word(gw_pin), .o_disc(dout),
    .o_sample_tick(tick), .o_staged(staged), .o_lunar_surface_flag(lunar),
    .o_att_hold_staging(ahold), .o_function_selector(fsel),
    .o_gse_word(gword), .o_gse_word_valid(gvalid),
    .o_gse_block_end(gend), .o_kdu_data(kdu));
  dprl_partner far (.i_clk(clk), .i_disc_req(dreq), .i_send(send),
    .i_last(last), .i_word(gw_in), .o_disc(dpin), .o_strobe(strobe),
    .o_end(bend), .o_word(gw_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin n_errors++; end_of_test(); end
    rd = prdata;
    chk(pslverr, e);
    psel <= 1'b0; pen <= 1'b0;
    // Let outputs launched at the access edge settle before callers look
    @(negedge clk);
  endtask
  // Waits for a sample tick, then lets sampled state settle
  task automatic tick_wait();
    int k;
    repeat (3) @(posedge clk);
    // Tick looked at only after three edges, so the sample sees the new pin
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      if (tick === 1'b1) break;
    end
    if (k == 50) begin n_errors++; end_of_test(); end
    repeat (3) @(negedge clk);
  endtask
  task automatic sc_reset();
    apb(1'b0, REG_STATUS, 32'h0, 1'b0);
    chk(rd, 32'h0);
    chk(fsel, SEL_RESET);
  endtask
  task automatic sc_sample();
    @(posedge clk) dreq <= 6'h34;
    tick_wait();
    chk(dout, 6'h34);
    @(posedge clk) dreq <= 6'h00;
    // Pin change is through the synchroniser, next tick still far off
    repeat (6) @(negedge clk);
    chk(dout, 6'h34);
    tick_wait();
    chk(dout, 6'h00);
  endtask
  task automatic sc_ascent();
    apb(1'b1, REG_CTRL, 32'h10, 1'b0);
    chk(lunar, 1'b1);
    @(posedge clk) dreq <= 6'h08;
    tick_wait();
    chk({staged, lunar, ahold}, 3'h5);
    @(posedge clk) dreq <= 6'h00;
    tick_wait();
    chk({staged, ahold}, 2'h2);
    apb(1'b1, REG_STATUS, 32'h80, 1'b0);
    chk(staged, 1'b0);
  endtask
  task automatic sc_inertial();
    apb(1'b1, REG_CTRL, 32'h3, 1'b0);
    chk(fsel, SEL_XFER_ALIGN);
    @(posedge clk) dreq <= 6'h03;
    tick_wait();
    chk(dout, 6'h00);
    apb(1'b1, REG_CTRL, 32'h1, 1'b0);
    tick_wait();
    chk(dout, 6'h03);
    apb(1'b0, REG_STATUS, 32'h0, 1'b0);
    chk(rd[14:12], SEL_RENDEZVOUS);
  endtask
  task automatic gse(input logic [15:0] w, input logic l);
    int k;
    @(posedge clk);
    send <= 1'b1; last <= l; gw_in <= w;
    @(posedge clk) send <= 1'b0;
    for (k = 0; k < 50 && gvalid !== 1'b1; k++) @(negedge clk);
    if (k == 50) begin n_errors++; end_of_test(); end
    chk({gvalid, gend, gword}, {1'b1, l, w});
    apb(1'b0, REG_GSE_WORD, 32'h0, 1'b0);
    chk(rd, {16'h0000, w});
    @(negedge clk);
    chk(gvalid, 1'b0);
    repeat (10) @(posedge clk);
  endtask
  // Velocity-to-be-gained in 0.1 fps counts, TPI time in 0.01 min counts
  task automatic sc_readout();
    logic [11:0] a;
    for (int i = 0; i < 5; i++) begin
      a = REG_RO_BASE + ((i == 4) ? 12'h03c : 12'(4 * i));
      apb(1'b1, a, 32'h4d2 + i, 1'b0);
      apb(1'b1, REG_RO_SEL, (i == 4) ? 32'hf : i, 1'b0);
      apb(1'b0, REG_RO_DATA, 32'h0, 1'b0);
      chk(rd, 32'h4d2 + i);
      chk(kdu, 32'h4d2 + i);
    end
    apb(1'b0, 12'h200, 32'h0, 1'b1);
    chk(rd, 32'h0);
  endtask

  initial begin
    n_errors = 0; checks_done = 0;
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; send = 1'b0; last = 1'b0;
    gw_in = 16'h0000; dreq = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sc_reset();
    sc_sample();
    sc_ascent();
    sc_inertial();
    gse(16'h5a3c, 1'b0);
    gse(16'hc3a5, 1'b1);
    sc_readout();
    end_of_test();
  end
endmodule
